// ==== common/fmh_pkg.sv ====
// Constants and types for the fax/modem host control block.
// Assumes a 200 MHz pclk; all times are derived from CLK_HZ here.
package fmh_pkg;
    // ****************************************************
    // Timing
    // ****************************************************
    localparam int CLK_HZ = 200_000_000;
    localparam int CONV_INIT_US = 5000;
    localparam int CONV_INIT_CYC = CONV_INIT_US * (CLK_HZ / 1_000_000);
    localparam int DTMF_MIN_MS = 40;
    localparam int DTMF_MIN_CYC = DTMF_MIN_MS * (CLK_HZ / 1000);
    localparam int VOICE_HZ = 9600;
    localparam int VOICE_CYC = CLK_HZ / VOICE_HZ;
    // ****************************************************
    // Map: word index, byte address is index times four
    // ****************************************************
    localparam int RAM_DEPTH = 64;
    localparam logic [6:0] IDX_CMD = 7'h00;
    localparam logic [6:0] IDX_VRX = 7'h3e;
    localparam logic [6:0] IDX_VTX = 7'h3f;
    localparam logic [6:0] IDX_MASK = 7'h40;
    localparam logic [6:0] IDX_SRC = 7'h41;
    localparam logic [6:0] IDX_CTRL = 7'h42;
    localparam logic [6:0] IDX_STAT = 7'h43;
    localparam logic [6:0] IDX_DSEL = 7'h44;
    localparam logic [6:0] IDX_DTHR = 7'h45;
    localparam logic [6:0] IDX_RATE = 7'h46;
    localparam logic [6:0] IDX_DIGIT = 7'h47;
    // ****************************************************
    // Commands, fields, reset values, limits
    // ****************************************************
    localparam logic [7:0] CMD_INIT = 8'h01;
    localparam logic [7:0] CMD_SLEEP = 8'h02;
    localparam int SRC_DIGIT = 0;
    localparam int SRC_WAKE = 1;
    localparam int SRC_ACK = 6;
    localparam int N_TGEN = 4;
    localparam int N_TDET = 16;
    localparam int CTRL_DTMF = 4;
    localparam int CTRL_VOICE = 5;
    localparam int CTRL_LOOP = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [15:0] RATE_RESET = 16'h2580;
    localparam logic [5:0] DTMF_MAX_ATT = 6'h23;
    localparam logic signed [5:0] TWIST_DB = 6'sh08;
    localparam logic [5:0] THR_MIN_ATT = 6'h0a;
    localparam logic [5:0] THR_MAX_ATT = 6'h2d;
    // Tone report from the detector datapath, same clock
    typedef struct packed {
        logic present;
        logic [5:0] power_att;
        logic signed [5:0] twist;
        logic [3:0] digit;
    } fmh_dtmf_t;
    typedef enum logic [3:0] {
        ST_CLEAR = 4'h1,
        ST_CONV = 4'h2,
        ST_READY = 4'h4,
        ST_SLEEP = 4'h8
    } fmh_state_t;
endpackage : fmh_pkg

// ==== hdl/fmh_host_ctrl.sv ====
// Host port, reset sequence, sleep, tones and voice path of the modem.
// Assumes an APB master on pclk and a same-clock tone/voice datapath.
`timescale 1ns/1ps
`default_nettype none
module fmh_host_ctrl
    import fmh_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_INIT_CYC,
    parameter int DTMF_CYCLES = DTMF_MIN_CYC,
    parameter int VOICE_CYCLES = VOICE_CYC,
    parameter bit FULL_VARIANT = 1'b1
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [8:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host pins
    input wire logic bus_style_select,
    input wire logic ring,
    output logic access_ack_n_o,
    output logic access_ack_n_oe,
    output logic host_irq_n_o,
    output logic host_irq_n_oe,
    // Datapath
    input wire logic [12:0] line_sample,
    input wire fmh_dtmf_t dtmf_in,
    output logic [12:0] line_out,
    output logic [N_TGEN-1:0] tone_gen_en,
    output logic loopback,
    output logic conv_init,
    output logic asleep
);
    // ****************************************************
    // A-law helpers
    // ****************************************************
    function automatic logic [7:0] alaw_enc(input logic [12:0] s);
        logic [11:0] m;
        logic [2:0] seg;
        logic [3:0] q;
        m = s[12] ? ~s[11:0] : s[11:0];
        seg = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (m[i + 4]) begin
                seg = 3'(i);
            end
        end
        q = (seg == 3'h0) ? m[4:1] : m[int'(seg) + 3 -: 4];
        return {~s[12], seg, q} ^ 8'h55;
    endfunction : alaw_enc

    function automatic logic [12:0] alaw_dec(input logic [7:0] c);
        logic [7:0] x;
        logic [11:0] m;
        x = c ^ 8'h55;
        m = {6'h00, x[3:0], 2'h1};
        if (x[6:4] != 3'h0) begin
            m = ({6'h00, 1'b1, x[3:0], 1'b1}) << (x[6:4] - 3'h1);
        end
        return x[7] ? {1'b0, m} : 13'(-{1'b0, m});
    endfunction : alaw_dec

    // ****************************************************
    // State
    // ****************************************************
    fmh_state_t state_r;
    logic [7:0] ram_r [RAM_DEPTH];
    logic [5:0] clr_idx_r;
    logic [31:0] conv_cnt_r;
    logic [7:0] mask_r, src_r, ctrl_r, digit_r;
    logic [3:0] dsel_r;
    logic [5:0] thr_r [N_TDET];
    logic [15:0] rate_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    logic [2:0] ring_s, style_s;
    logic ring_lvl_r, ring_prev_r;
    logic [31:0] dur_r, vcnt_r;
    logic digit_ok;

    wire logic [6:0] idx = paddr[8:2];
    wire logic acc = psel & penable & ce;
    wire logic wr_go = acc & pready_r & pwrite & ~pslverr_r;
    wire logic is_ram = (idx < 7'(RAM_DEPTH));
    wire logic mapped = is_ram | (idx <= IDX_DIGIT);
    wire logic ready = (state_r == ST_READY);
    wire logic cmd_go = wr_go & (idx == IDX_CMD) & ready;
    wire logic ring_rise = ring_lvl_r & ~ring_prev_r;
    wire logic vtick = (vcnt_r == 32'(VOICE_CYCLES - 1));
    wire logic [5:0] twist_abs = dtmf_in.twist[5] ?
        6'(-dtmf_in.twist) : dtmf_in.twist;

    // ****************************************************
    // Pin synchronisers: ring level taken once last two stages agree
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_s <= 3'h0;
            style_s <= 3'h0;
            ring_lvl_r <= 1'b0;
            ring_prev_r <= 1'b0;
        end else if (ce) begin
            ring_s <= {ring_s[1:0], ring};
            style_s <= {style_s[1:0], bus_style_select};
            if (ring_s[1] == ring_s[2]) begin
                ring_lvl_r <= ring_s[2];
            end
            ring_prev_r <= ring_lvl_r;
        end
    end

    // ****************************************************
    // Reset sequence and command handling
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_CLEAR;
            clr_idx_r <= 6'h00;
            conv_cnt_r <= 32'h0;
        end else if (ce) begin
            case (state_r)
                ST_CLEAR: begin
                    clr_idx_r <= clr_idx_r + 6'h01;
                    if (clr_idx_r == 6'(RAM_DEPTH - 1)) begin
                        state_r <= ST_CONV;
                        conv_cnt_r <= 32'h0;
                    end
                end
                ST_CONV: begin
                    conv_cnt_r <= conv_cnt_r + 32'h1;
                    if (conv_cnt_r == 32'(CONV_CYCLES - 1)) begin
                        state_r <= ST_READY;
                    end
                end
                ST_READY: begin
                    // Commands only count once the sequence is over
                    if (cmd_go && pwdata[7:0] == CMD_INIT) begin
                        state_r <= ST_CLEAR;
                        clr_idx_r <= 6'h00;
                    end else if (cmd_go && pwdata[7:0] == CMD_SLEEP) begin
                        state_r <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    // Reduced part ignores ring and writes here
                    if (FULL_VARIANT && (ring_rise || wr_go)) begin
                        state_r <= ST_READY;
                    end
                end
                default: state_r <= ST_CLEAR;
            endcase
        end
    end

    // ****************************************************
    // Shared RAM: clear, host writes, voice sample
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < RAM_DEPTH; i++) begin
                ram_r[i] <= 8'h00;
            end
        end else if (ce) begin
            if (state_r == ST_CLEAR) begin
                ram_r[clr_idx_r] <= 8'h00;
            end else if (wr_go && is_ram) begin
                ram_r[idx[5:0]] <= pwdata[7:0];
            end
            if (state_r == ST_CONV && conv_cnt_r == 32'(CONV_CYCLES - 1)) begin
                ram_r[IDX_CMD[5:0]] <= 8'h00;
            end
            if (ready && vtick && ctrl_r[CTRL_VOICE]) begin
                // Loop-back feeds the decoded output to the coder
                ram_r[IDX_VRX[5:0]] <= alaw_enc(ctrl_r[CTRL_LOOP] ?
                    line_out : line_sample);
            end
        end
    end

    // ****************************************************
    // Voice sample clock and line output
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vcnt_r <= 32'h0;
            line_out <= 13'h0000;
        end else if (ce) begin
            vcnt_r <= vtick ? 32'h0 : vcnt_r + 32'h1;
            if (vtick && ctrl_r[CTRL_VOICE]) begin
                line_out <= alaw_dec(ram_r[IDX_VTX[5:0]]);
            end
        end
    end

    // ****************************************************
    // Control registers; init restores ctrl and rate only, not irqs
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= MASK_RESET;
            ctrl_r <= CTRL_RESET;
            rate_r <= RATE_RESET;
            dsel_r <= 4'h0;
            for (int i = 0; i < N_TDET; i++) begin
                thr_r[i] <= THR_MAX_ATT;
            end
        end else if (ce) begin
            if (state_r == ST_CLEAR) begin
                ctrl_r <= CTRL_RESET;
                rate_r <= RATE_RESET;
            end else if (wr_go) begin
                case (idx)
                    IDX_MASK: mask_r <= pwdata[7:0];
                    IDX_CTRL: ctrl_r <= pwdata[7:0];
                    IDX_DSEL: dsel_r <= pwdata[3:0];
                    IDX_RATE: rate_r <= pwdata[15:0];
                    IDX_DTHR: begin
                        // Out of range settings saturate to the edge
                        if (pwdata[5:0] < THR_MIN_ATT) begin
                            thr_r[dsel_r] <= THR_MIN_ATT;
                        end else if (pwdata[5:0] > THR_MAX_ATT) begin
                            thr_r[dsel_r] <= THR_MAX_ATT;
                        end else begin
                            thr_r[dsel_r] <= pwdata[5:0];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ****************************************************
    // DTMF validity: power, twist, and held long enough
    // ****************************************************
    assign digit_ok = dtmf_in.present && dtmf_in.power_att < DTMF_MAX_ATT
        && twist_abs <= 6'(TWIST_DB);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dur_r <= 32'h0;
            digit_r <= 8'h00;
        end else if (ce) begin
            dur_r <= !digit_ok ? 32'h0 :
                (dur_r <= 32'(DTMF_CYCLES) ? dur_r + 32'h1 : dur_r);
            if (dur_r == 32'(DTMF_CYCLES)) begin
                digit_r <= {4'h0, dtmf_in.digit};
            end
        end
    end

    // ****************************************************
    // Interrupt source: write one to clear, set wins
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_r <= 8'h00;
        end else if (ce) begin
            logic [7:0] set_v;
            set_v = 8'h00;
            set_v[SRC_ACK] = state_r == ST_CONV
                && conv_cnt_r == 32'(CONV_CYCLES - 1);
            set_v[SRC_DIGIT] = dur_r == 32'(DTMF_CYCLES);
            set_v[SRC_WAKE] = state_r == ST_SLEEP && FULL_VARIANT
                && (ring_rise || wr_go);
            if (wr_go && idx == IDX_SRC) begin
                src_r <= (src_r & ~pwdata[7:0]) | set_v;
            end else begin
                src_r <= src_r | set_v;
            end
        end
    end

    // ****************************************************
    // APB answer: one wait state, then ready for one cycle
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else if (ce) begin
            pready_r <= acc & ~pready_r;
            pslverr_r <= acc & ~pready_r & ~mapped;
            if (acc && !pready_r) begin
                prdata_r <= 32'h0;
                if (is_ram) begin
                    prdata_r <= {24'h0, ram_r[idx[5:0]]};
                end else begin
                    case (idx)
                        IDX_MASK: prdata_r <= {24'h0, mask_r};
                        IDX_SRC: prdata_r <= {24'h0, src_r};
                        IDX_CTRL: prdata_r <= {24'h0, ctrl_r};
                        IDX_STAT: prdata_r <= {28'h0, style_s[2],
                            FULL_VARIANT, state_r == ST_SLEEP, ready};
                        IDX_DSEL: prdata_r <= {28'h0, dsel_r};
                        IDX_DTHR: prdata_r <= {26'h0, thr_r[dsel_r]};
                        IDX_RATE: prdata_r <= {16'h0, rate_r};
                        IDX_DIGIT: prdata_r <= {24'h0, digit_r};
                        default: prdata_r <= 32'h0;
                    endcase
                end
            end
        end
    end

    // ****************************************************
    // Output flops: open-drain pins drive low when enabled
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            access_ack_n_oe <= 1'b0;
            host_irq_n_oe <= 1'b0;
            tone_gen_en <= 4'h0;
            loopback <= 1'b0;
            conv_init <= 1'b0;
            asleep <= 1'b0;
        end else if (ce) begin
            access_ack_n_oe <= acc & ~pready_r;
            host_irq_n_oe <= |(src_r & mask_r);
            // DTMF takes generators two and three
            tone_gen_en <= ctrl_r[3:0] | {ctrl_r[CTRL_DTMF],
                ctrl_r[CTRL_DTMF], 2'h0};
            loopback <= ctrl_r[CTRL_LOOP];
            conv_init <= state_r != ST_READY && state_r != ST_SLEEP;
            asleep <= state_r == ST_SLEEP;
        end
    end
    assign access_ack_n_o = 1'b0;
    assign host_irq_n_o = 1'b0;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);
    a_ack_with_ready: assert property (acc && !pready_r |=> pready_r
        && access_ack_n_oe ##1 !access_ack_n_oe)
        else $error("ack not paired with ready");
    a_seq_done_ack: assert property ($rose(ready) && $past(state_r)
        == ST_CONV |-> src_r[SRC_ACK] && ram_r[0] == 8'h00)
        else $error("sequence end lacks ack or clear");
    a_busy_ignores: assert property (!ready && state_r != ST_SLEEP
        && wr_go && idx == IDX_CMD |=> state_r != ST_SLEEP)
        else $error("command taken while busy");
    a_reduced_stays: assert property (!FULL_VARIANT
        && state_r == ST_SLEEP |=> state_r == ST_SLEEP)
        else $error("reduced part woke");
    a_ring_wakes: assert property (FULL_VARIANT && state_r == ST_SLEEP
        && ring_rise |=> ready ##1 asleep == 1'b0)
        else $error("ring did not wake");
    a_init_keeps_irq: assert property (cmd_go && pwdata[7:0] == CMD_INIT
        && !(idx == IDX_SRC) |=> mask_r == $past(mask_r)
        && (src_r | ~$past(src_r)) == 8'hff)
        else $error("init disturbed interrupt registers");
    a_thr_range: assert property (thr_r[dsel_r] >= THR_MIN_ATT
        && thr_r[dsel_r] <= THR_MAX_ATT)
        else $error("threshold out of range");
    a_irq_follows: assert property (##1 host_irq_n_oe ==
        $past(|(src_r & mask_r)))
        else $error("irq pin mismatch");
    a_digit_cause: assert property ($rose(src_r[SRC_DIGIT]) |->
        $past(digit_ok, 2) && $past(dur_r) == 32'(DTMF_CYCLES))
        else $error("digit without valid tone");
    a_clear_len: assert property ($rose(state_r == ST_CONV) |->
        $past(clr_idx_r) == 6'(RAM_DEPTH - 1))
        else $error("clear sweep short");
    c_reset_done: cover property ($rose(ready));
    c_sleep_wake: cover property (state_r == ST_SLEEP ##1 ready);
    c_digit: cover property ($rose(src_r[SRC_DIGIT]));
    c_err: cover property (pslverr_r);
endmodule : fmh_host_ctrl
`default_nettype wire

// ==== verif/fmh_line_model.sv ====
// Far side of the modem block: line, tone source, ring and pull-ups.
// Assumes the bench requests tones and ring on pclk.
`timescale 1ns/1ps
`default_nettype none
module fmh_line_model
    import fmh_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Requests from the bench
    input wire logic tone_on,
    input wire logic [3:0] tone_digit,
    input wire logic [5:0] tone_att,
    input wire logic signed [5:0] tone_twist,
    input wire logic ring_req,
    input wire logic [12:0] level,
    // Open-drain pins of the device
    input wire logic ack_o,
    input wire logic ack_oe,
    input wire logic irq_o,
    input wire logic irq_oe,
    output logic ack_l,
    output logic irq_l,
    // Line side
    output logic ring,
    output logic [12:0] line_sample,
    output fmh_dtmf_t dtmf_in
);
    logic [15:0] noise_r = 16'h0000;

    // Pull-ups win unless the device sinks the line
    assign ack_l = ack_oe ? ack_o : 1'b1;
    assign irq_l = irq_oe ? irq_o : 1'b1;

    // Fields wander without a tone so stale values never look valid
    always @(posedge pclk) begin
        noise_r <= noise_r + 16'h3b1d;
        ring <= ring_req;
        line_sample <= level;
        dtmf_in.present <= tone_on;
        dtmf_in.power_att <= tone_on ? tone_att : noise_r[5:0];
        dtmf_in.twist <= tone_on ? tone_twist : noise_r[11:6];
        dtmf_in.digit <= tone_on ? tone_digit : noise_r[15:12];
    end
endmodule : fmh_line_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the modem host control block.
// Assumes the short parameter values set at the instance below.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import fmh_pkg::*;
;
    localparam int DTMF = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [8:0] paddr = 9'h000;
    logic [31:0] pwdata = 32'h0;
    logic ce = 1'b1;
    logic bus_style_select = 1'b0;
    logic tone_on = 1'b0;
    logic [3:0] tone_digit = 4'h0;
    logic [5:0] tone_att = 6'h00;
    logic signed [5:0] tone_twist = 6'sh00;
    logic ring_req = 1'b0;
    logic [12:0] level = 13'h0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, ack_o, ack_oe, irq_o, irq_oe, ack_l, irq_l;
    logic ring, loopback, conv_init, asleep, asleep_red;
    logic [12:0] line_sample, line_out;
    logic [N_TGEN-1:0] tone_gen_en;
    fmh_dtmf_t dtmf_in;
    int failures = 0;
    int num_checks = 0;

    fmh_host_ctrl #(.CONV_CYCLES(200), .DTMF_CYCLES(DTMF),
        .VOICE_CYCLES(16), .FULL_VARIANT(1'b1)) i_dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_style_select(bus_style_select),
        .ring(ring), .access_ack_n_o(ack_o), .access_ack_n_oe(ack_oe),
        .host_irq_n_o(irq_o), .host_irq_n_oe(irq_oe),
        .line_sample(line_sample), .dtmf_in(dtmf_in),
        .line_out(line_out), .tone_gen_en(tone_gen_en),
        .loopback(loopback), .conv_init(conv_init), .asleep(asleep));

    // Reduced variant on the same bus; only its sleep flag is watched
    fmh_host_ctrl #(.CONV_CYCLES(200), .DTMF_CYCLES(DTMF),
        .VOICE_CYCLES(16), .FULL_VARIANT(1'b0)) i_dut_red (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .bus_style_select(bus_style_select), .ring(ring),
        .access_ack_n_o(), .access_ack_n_oe(), .host_irq_n_o(),
        .host_irq_n_oe(), .line_sample(line_sample), .dtmf_in(dtmf_in),
        .line_out(), .tone_gen_en(), .loopback(), .conv_init(),
        .asleep(asleep_red));

    fmh_line_model i_line (.pclk(pclk), .tone_on(tone_on),
        .tone_digit(tone_digit), .tone_att(tone_att),
        .tone_twist(tone_twist), .ring_req(ring_req), .level(level),
        .ack_o(ack_o), .ack_oe(ack_oe), .irq_o(irq_o), .irq_oe(irq_oe),
        .ack_l(ack_l), .irq_l(irq_l), .ring(ring),
        .line_sample(line_sample), .dtmf_in(dtmf_in));

    initial begin
        forever #2.5 pclk = ~pclk;
    end

    // ****
    // Bus and compare tasks
    // ****
    task automatic stop_test();
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : chk

    // Entered just after a rising edge; holds the request until pready
    task automatic apb(input logic w, input logic [6:0] idx,
                       input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        chk({31'h0, ack_l}, 32'h0, "ack pin");
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never rewrites psel at once
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [6:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rdc(input logic [6:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp, "read data");
    endtask : rdc

    // Polling keeps the wait bounded by the loop count
    task automatic wait_src(input int b);
        int k;
        k = 0;
        do begin
            apb(1'b0, IDX_SRC, 32'h0);
            k++;
        end while (rd[b] !== 1'b1 && k < 400);
        chk({31'h0, rd[b]}, 32'h1, "source bit");
    endtask : wait_src

    task automatic tone(input logic [5:0] att, input logic [5:0] tw);
        tone_digit <= 4'h7;
        tone_att <= att;
        tone_twist <= tw;
        tone_on <= 1'b1;
        repeat (DTMF + 10) @(posedge pclk);
        tone_on <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : tone

    // ****
    // Test sequence
    // ****
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (80) @(posedge pclk);
        wr(IDX_CMD, {24'h0, CMD_SLEEP});
        rdc(IDX_STAT, 32'h4);
        // Enable low must freeze the converter count
        ce <= 1'b0;
        repeat (400) @(posedge pclk);
        ce <= 1'b1;
        rdc(IDX_STAT, 32'h4);
        wait_src(SRC_ACK);
        rdc(IDX_CMD, 32'h0);
        rdc(IDX_STAT, 32'h5);
        rdc(IDX_RATE, {16'h0, RATE_RESET});
        wr(7'h05, 32'ha5);
        rdc(7'h05, 32'ha5);
        apb(1'b1, 7'h50, 32'h1);
        chk({31'h0, err}, 32'h1, "unmapped");
        wr(IDX_DTHR, 32'h30);
        rdc(IDX_DTHR, {26'h0, THR_MAX_ATT});
        wr(IDX_DTHR, 32'h05);
        rdc(IDX_DTHR, {26'h0, THR_MIN_ATT});
        wr(IDX_DSEL, 32'h3);
        rdc(IDX_DTHR, {26'h0, THR_MAX_ATT});
        wr(IDX_DTHR, 32'h14);
        rdc(IDX_DTHR, 32'h14);
        wr(IDX_CTRL, 32'h50);
        repeat (2) @(posedge pclk);
        chk({27'h0, loopback, tone_gen_en}, 32'h1c, "tones");
        wr(IDX_SRC, 32'hff);
        wr(IDX_MASK, 32'h01);
        tone(6'h14, 6'h08);
        rdc(IDX_DIGIT, 32'h7);
        chk({31'h0, irq_l}, 32'h0, "irq pin");
        wr(IDX_SRC, 32'h01);
        tone(6'h23, 6'h00);
        tone(6'h14, 6'h37);
        rdc(IDX_SRC, 32'h0);
        chk({31'h0, irq_l}, 32'h1, "irq pin");
        wr(IDX_MASK, 32'h41);
        wr(IDX_CMD, {24'h0, CMD_INIT});
        repeat (2) @(posedge pclk);
        chk({31'h0, conv_init}, 32'h1, "conv init");
        wait_src(SRC_ACK);
        chk({31'h0, conv_init}, 32'h0, "conv done");
        rdc(IDX_MASK, 32'h41);
        rdc(7'h05, 32'h0);
        rdc(IDX_CTRL, 32'h0);
        wr(IDX_CTRL, 32'h20);
        repeat (40) @(posedge pclk);
        rdc(IDX_VRX, 32'hd5);
        level <= 13'h0fff;
        repeat (40) @(posedge pclk);
        rdc(IDX_VRX, 32'haa);
        wr(IDX_VTX, 32'haa);
        level <= 13'h0000;
        repeat (40) @(posedge pclk);
        chk({19'h0, line_out}, 32'hfc0, "line out");
        rdc(IDX_VRX, 32'hd5);
        // Loop-back must code the expanded output, not the quiet line
        wr(IDX_CTRL, 32'h60);
        repeat (40) @(posedge pclk);
        rdc(IDX_VRX, 32'haa);
        bus_style_select <= 1'b1;
        repeat (6) @(posedge pclk);
        rdc(IDX_STAT, 32'hd);
        wr(IDX_SRC, 32'hff);
        wr(IDX_CMD, {24'h0, CMD_SLEEP});
        repeat (4) @(posedge pclk);
        chk({31'h0, asleep}, 32'h1, "asleep");
        ring_req <= 1'b1;
        repeat (10) @(posedge pclk);
        chk({31'h0, asleep}, 32'h0, "ring wake");
        chk({31'h0, asleep_red}, 32'h1, "reduced ring");
        wait_src(SRC_WAKE);
        ring_req <= 1'b0;
        wr(IDX_CMD, {24'h0, CMD_SLEEP});
        repeat (4) @(posedge pclk);
        chk({31'h0, asleep}, 32'h1, "asleep again");
        wr(7'h09, 32'h33);
        repeat (2) @(posedge pclk);
        chk({31'h0, asleep}, 32'h0, "write wake");
        chk({31'h0, asleep_red}, 32'h1, "reduced write");
        rdc(7'h09, 32'h33);
        // Mid-run hardware reset, held past the minimum pulse width
        presetn <= 1'b0;
        repeat (141) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({31'h0, asleep_red}, 32'h0, "reduced reset");
        wait_src(SRC_ACK);
        rdc(IDX_MASK, {24'h0, MASK_RESET});
        rdc(7'h09, 32'h0);
        stop_test();
    end

    // A hang costs one mismatch and ends the run
    initial begin
        #200000;
        failures++;
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
